// File: rtl/pfclps_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - power-select range code maps to 100, 90, 80 or 70 percent power.
// - switching starts only above brown-in and below the upper input peak limit.
// - turn off when line stays below undervoltage threshold beyond debounce.
// - normal debounce outlasts one missing half-cycle at 47 to 63 Hz.
// - after brown-out, ramp error voltage linearly to zero over 1 ms.
// - soft shutdown starts at the next line zero crossing.
// - after brown-out, rerun all start-up checks before brown-in again.
// - after start-up timer, use lowered threshold and extended debounce.
// - line back above lowered threshold restarts start-up timer, else shut down.
// - after timer, above lowered threshold restores normal threshold and debounce.
// - square-wave line detected uses the further reduced threshold.
// - bias parts start above upper lockout, run until below lower lockout.
// - self-biased parts take lockout from the driver-supply comparator.
// - end on-time whenever switch current reaches the active limit.
// - low-line limit after 3 low half-cycle peaks; high-line after one high.
// - line drop-out beyond 37 ms reverts to low-line set-points.
// - instantaneous level above high-line threshold sets high-line at once.
// - current limit reached before on-time bound enters safe-area mode.
// - safe-area mode forces fixed off-time and lowers error voltage by half of full scale.
// - overvoltage stops switching at once; resume after hysteresis drop.
// - power-up checks, then brown-in, latch power select, then switch.
module pfclps_supervisor
  import pfclps_pkg::*;
#(
  parameter bit SELF_BIASED = 1'b1,
  parameter int unsigned BROWNOUT_CYCLES = pfclps_pkg::BROWNOUT_CYC,
  parameter int unsigned EXT_BROWNOUT_CYCLES = pfclps_pkg::EXT_BROWNOUT_CYC,
  parameter int unsigned STARTUP_CYCLES = pfclps_pkg::STARTUP_CYC,
  parameter int unsigned DROPOUT_CYCLES = pfclps_pkg::DROPOUT_CYC,
  parameter int unsigned SOFTOFF_CYCLES = pfclps_pkg::SOFT_SHUTDOWN_CYC,
  parameter int unsigned SOA_OFF_CYCLES = pfclps_pkg::SAFE_AREA_OFF_CYC,
  parameter int unsigned SOA_ON_CYCLES = pfclps_pkg::SAFE_AREA_ON_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // supply comparators
  input wire logic bias_above_upper_in,
  input wire logic bias_above_lower_in,
  input wire logic driver_supply_ok_in,
  // start-up checks
  input wire logic pin_checks_ok_in,
  input wire logic feedback_valid_in,
  input wire logic over_temp_in,
  // line monitor comparators
  input wire logic line_above_brown_in_in,
  input wire logic line_above_undervoltage_in,
  input wire logic line_above_lowered_in,
  input wire logic line_above_squarewave_in,
  input wire logic line_peak_over_limit_in,
  input wire logic line_square_wave_in,
  input wire logic line_zero_cross_in,
  input wire logic line_above_high_in,
  input wire logic half_cycle_peak_in,
  input wire logic peak_below_low_in,
  input wire logic peak_above_high_in,
  // power select range code: 0 open .. 3 short
  input wire logic [1:0] power_select_input_in,
  // switching cycle
  input wire logic switch_on_in,
  input wire logic switch_current_limit_in,
  input wire logic feedback_overvoltage_in,
  input wire logic feedback_below_hyst_in,
  // outputs
  output logic switch_enable_out,
  output logic end_on_time_out,
  output pfclps_pkg::pfclps_pwr_e power_level_out,
  output logic high_line_out,
  output logic [pfclps_pkg::ERR_W-1:0] error_voltage_limit_out,
  output logic safe_area_active_out,
  output logic overvoltage_out
);
  import pfclps_pkg::*;

  localparam int unsigned NSYNC = 19;
  localparam int unsigned TW = 32;

  initial
  begin
    if (BROWNOUT_CYCLES < 1 || EXT_BROWNOUT_CYCLES < 1 || STARTUP_CYCLES < 1
        || SOFTOFF_CYCLES < 1 || SOA_OFF_CYCLES < 1 || DROPOUT_CYCLES < 1)
      $error("pfclps_supervisor: counts must be at least one");
  end

  pfclps_sync_if #(.W(NSYNC)) sync_if ();

  assign sync_if.raw = {bias_above_upper_in, bias_above_lower_in, driver_supply_ok_in,
    pin_checks_ok_in, feedback_valid_in, over_temp_in, line_above_brown_in_in,
    line_above_undervoltage_in, line_above_lowered_in, line_above_squarewave_in,
    line_peak_over_limit_in, line_square_wave_in, line_zero_cross_in,
    line_above_high_in, half_cycle_peak_in, peak_below_low_in, peak_above_high_in,
    feedback_overvoltage_in, feedback_below_hyst_in};

  pfclps_sync #(.W(NSYNC)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .port_if(sync_if)
  );

  logic s_bias_up;
  logic s_bias_lo;
  logic s_drv;
  logic s_pins;
  logic s_fb;
  logic s_ot;
  logic s_bi;
  logic s_uv;
  logic s_low;
  logic s_sq_th;
  logic s_over;
  logic s_sq;
  logic s_zc;
  logic s_hi;
  logic s_pk;
  logic s_pk_lo;
  logic s_pk_hi;
  logic s_ov;
  logic s_ov_clr;
  assign {s_bias_up, s_bias_lo, s_drv, s_pins, s_fb, s_ot, s_bi, s_uv, s_low, s_sq_th,
    s_over, s_sq, s_zc, s_hi, s_pk, s_pk_lo, s_pk_hi, s_ov, s_ov_clr} = sync_if.synced;

  function automatic logic [TW-1:0] dec_sat(input logic [TW-1:0] v);
    dec_sat = (v == '0) ? '0 : v - 32'h1;
  endfunction

  // sequencer state
  pfclps_state_e state_q, state_d;
  logic [TW-1:0] bo_cnt_q, bo_cnt_d;
  logic [TW-1:0] su_cnt_q, su_cnt_d;
  logic [TW-1:0] so_cnt_q, so_cnt_d;
  logic ntc_mode_q, ntc_mode_d;
  logic su_done_q, su_done_d;
  logic pwr_lock_q, pwr_lock_d;
  logic [9:0] err_q, err_d;
  pfclps_pwr_e pwr_q, pwr_d;
  logic sup_ok;
  logic line_ok;
  logic bo_expired;

  always_comb
  begin
    sup_ok = SELF_BIASED ? s_drv : ((state_q == PFCLPS_ST_LOCKOUT) ? s_bias_up : s_bias_lo);
    if (s_sq)
      line_ok = s_sq_th;
    else if (ntc_mode_q)
      line_ok = s_low;
    else
      line_ok = s_uv;
    bo_expired = (bo_cnt_q == 32'h1);
    state_d = state_q;
    bo_cnt_d = bo_cnt_q;
    su_cnt_d = dec_sat(su_cnt_q);
    so_cnt_d = so_cnt_q;
    ntc_mode_d = ntc_mode_q;
    su_done_d = su_done_q;
    pwr_lock_d = pwr_lock_q;
    pwr_d = pwr_q;
    err_d = err_q;
    case (state_q)
      PFCLPS_ST_LOCKOUT:
      begin
        err_d = '0;
        if (sup_ok)
          state_d = PFCLPS_ST_CHECKS;
      end
      PFCLPS_ST_CHECKS:
      begin
        if (s_pins && s_fb && !s_ot)
          state_d = PFCLPS_ST_WAIT_BI;
      end
      PFCLPS_ST_WAIT_BI:
      begin
        if (s_bi && !s_over)
        begin
          state_d = PFCLPS_ST_RUN;
          pwr_d = pfclps_pwr_e'(power_select_input_in);
          pwr_lock_d = 1'b1;
          su_cnt_d = STARTUP_CYCLES[TW-1:0];
          su_done_d = 1'b0;
          ntc_mode_d = 1'b0;
          bo_cnt_d = '0;
          err_d = ERR_FULL;
        end
      end
      PFCLPS_ST_RUN:
      begin
        if (!su_done_q && su_cnt_q == 32'h1)
        begin
          su_done_d = 1'b1;
          ntc_mode_d = 1'b1;
        end
        if (line_ok)
        begin
          if (ntc_mode_q && bo_cnt_q != '0)
            su_cnt_d = STARTUP_CYCLES[TW-1:0];
          if (su_done_q && ntc_mode_q && s_low && !s_sq)
            ntc_mode_d = 1'b0;
          bo_cnt_d = '0;
        end
        else if (bo_cnt_q == '0)
          bo_cnt_d = ntc_mode_q ? EXT_BROWNOUT_CYCLES[TW-1:0] : BROWNOUT_CYCLES[TW-1:0];
        else
          bo_cnt_d = dec_sat(bo_cnt_q);
        if (bo_expired && !line_ok)
          state_d = PFCLPS_ST_WAIT_ZC;
        if (!sup_ok)
          state_d = PFCLPS_ST_LOCKOUT;
      end
      PFCLPS_ST_WAIT_ZC:
      begin
        if (s_zc)
        begin
          state_d = PFCLPS_ST_SOFTOFF;
          so_cnt_d = SOFTOFF_CYCLES[TW-1:0];
        end
      end
      PFCLPS_ST_SOFTOFF:
      begin
        so_cnt_d = dec_sat(so_cnt_q);
        err_d = 10'((so_cnt_q * 32'(ERR_FULL)) / SOFTOFF_CYCLES);
        if (so_cnt_q <= 32'h1)
        begin
          state_d = PFCLPS_ST_LOCKOUT;
          err_d = '0;
          pwr_lock_d = 1'b0;
        end
      end
      default:
      begin
        state_d = PFCLPS_ST_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_q <= PFCLPS_ST_LOCKOUT;
      bo_cnt_q <= '0;
      su_cnt_q <= '0;
      so_cnt_q <= '0;
      ntc_mode_q <= 1'b0;
      su_done_q <= 1'b0;
      pwr_lock_q <= 1'b0;
      pwr_q <= PFCLPS_PWR_100;
      err_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      bo_cnt_q <= bo_cnt_d;
      su_cnt_q <= su_cnt_d;
      so_cnt_q <= so_cnt_d;
      ntc_mode_q <= ntc_mode_d;
      su_done_q <= su_done_d;
      pwr_lock_q <= pwr_lock_d;
      pwr_q <= pwr_d;
      err_q <= err_d;
    end
  end

  // line-dependent current limit selection
  logic hl_q, hl_d;
  logic [1:0] lo_cnt_q, lo_cnt_d;
  logic [TW-1:0] do_cnt_q, do_cnt_d;
  logic pk_prev_q, pk_prev_d;

  always_comb
  begin
    hl_d = hl_q;
    lo_cnt_d = lo_cnt_q;
    pk_prev_d = s_pk;
    do_cnt_d = s_uv ? '0 : ((do_cnt_q == DROPOUT_CYCLES[TW-1:0]) ? do_cnt_q : do_cnt_q + 32'h1);
    if (s_pk && !pk_prev_q)
    begin
      if (s_pk_hi)
      begin
        hl_d = 1'b1;
        lo_cnt_d = '0;
      end
      else if (s_pk_lo)
      begin
        if (lo_cnt_q == 2'(LOW_LINE_HALF_CYCLES - 1))
        begin
          hl_d = 1'b0;
          lo_cnt_d = '0;
        end
        else
          lo_cnt_d = lo_cnt_q + 2'h1;
      end
      else
        lo_cnt_d = '0;
    end
    if (do_cnt_q == DROPOUT_CYCLES[TW-1:0])
    begin
      hl_d = 1'b0;
      lo_cnt_d = '0;
    end
    if (s_hi)
      hl_d = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      hl_q <= 1'b0;
      lo_cnt_q <= '0;
      do_cnt_q <= '0;
      pk_prev_q <= 1'b0;
    end
    else
    begin
      hl_q <= hl_d;
      lo_cnt_q <= lo_cnt_d;
      do_cnt_q <= do_cnt_d;
      pk_prev_q <= pk_prev_d;
    end
  end

  // safe-area and overvoltage
  logic [TW-1:0] on_cnt_q, on_cnt_d;
  logic [TW-1:0] soa_cnt_q, soa_cnt_d;
  logic ov_q, ov_d;

  always_comb
  begin
    on_cnt_d = switch_on_in ? ((on_cnt_q == 32'hffffffff) ? on_cnt_q : on_cnt_q + 32'h1) : '0;
    soa_cnt_d = dec_sat(soa_cnt_q);
    if (switch_on_in && switch_current_limit_in && on_cnt_q < SOA_ON_CYCLES[TW-1:0])
      soa_cnt_d = SOA_OFF_CYCLES[TW-1:0];
    ov_d = ov_q;
    if (s_ov)
      ov_d = 1'b1;
    else if (s_ov_clr)
      ov_d = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      on_cnt_q <= '0;
      soa_cnt_q <= '0;
      ov_q <= 1'b0;
    end
    else
    begin
      on_cnt_q <= on_cnt_d;
      soa_cnt_q <= soa_cnt_d;
      ov_q <= ov_d;
    end
  end

  logic run_ok;
  assign run_ok = (state_q == PFCLPS_ST_RUN) || (state_q == PFCLPS_ST_WAIT_ZC)
    || (state_q == PFCLPS_ST_SOFTOFF);
  assign switch_enable_out = run_ok && pwr_lock_q && !ov_q && !s_ov && (soa_cnt_q == '0);
  assign end_on_time_out = switch_current_limit_in;
  assign power_level_out = pwr_q;
  assign high_line_out = hl_q;
  assign error_voltage_limit_out = (soa_cnt_q != '0 && err_q > ERR_HALF)
    ? 10'(err_q - ERR_HALF) : ((soa_cnt_q != '0) ? '0 : err_q);
  assign safe_area_active_out = (soa_cnt_q != '0);
  assign overvoltage_out = ov_q;
endmodule
`default_nettype wire

// File: common/pfclps_pkg.sv
package pfclps_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // durations in their own units
  localparam int unsigned BROWNOUT_DEBOUNCE_US = 26000;
  localparam int unsigned EXT_BROWNOUT_DEBOUNCE_US = 64000;
  localparam int unsigned STARTUP_TIMER_US = 100000;
  localparam int unsigned DROPOUT_US = 37000;
  localparam int unsigned SOFT_SHUTDOWN_US = 1000;
  localparam int unsigned SAFE_AREA_OFF_NS = 1000;
  localparam int unsigned SAFE_AREA_ON_BOUND_NS = 400;
  // derived cycle counts
  localparam int unsigned BROWNOUT_CYC = BROWNOUT_DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned EXT_BROWNOUT_CYC = EXT_BROWNOUT_DEBOUNCE_US * (CLK_HZ / 1000000);
  localparam int unsigned STARTUP_CYC = STARTUP_TIMER_US * (CLK_HZ / 1000000);
  localparam int unsigned DROPOUT_CYC = DROPOUT_US * (CLK_HZ / 1000000);
  localparam int unsigned SOFT_SHUTDOWN_CYC = SOFT_SHUTDOWN_US * (CLK_HZ / 1000000);
  localparam int unsigned SAFE_AREA_OFF_CYC = (SAFE_AREA_OFF_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SAFE_AREA_ON_CYC = (SAFE_AREA_ON_BOUND_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned LOW_LINE_HALF_CYCLES = 3;
  localparam int unsigned ERR_W = 10;
  localparam logic [9:0] ERR_FULL = 10'h3ff;
  localparam logic [9:0] ERR_HALF = 10'h200;
  // power levels, percent
  typedef enum logic [1:0] {
    PFCLPS_PWR_100 = 2'h0,
    PFCLPS_PWR_90 = 2'h1,
    PFCLPS_PWR_80 = 2'h2,
    PFCLPS_PWR_70 = 2'h3
  } pfclps_pwr_e;
  typedef enum logic [5:0] {
    PFCLPS_ST_LOCKOUT = 6'h01,
    PFCLPS_ST_CHECKS = 6'h02,
    PFCLPS_ST_WAIT_BI = 6'h04,
    PFCLPS_ST_RUN = 6'h08,
    PFCLPS_ST_WAIT_ZC = 6'h10,
    PFCLPS_ST_SOFTOFF = 6'h20
  } pfclps_state_e;
endpackage

// File: common/pfclps_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfclps_sync_if #(parameter int unsigned W = 16);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface
`default_nettype wire

// File: rtl/pfclps_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for the comparator inputs
module pfclps_sync #(
  parameter int unsigned W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  pfclps_sync_if.sync port_if
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = port_if.raw;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign port_if.synced = sync_q;
endmodule
`default_nettype wire

// File: verification/pfclps_sva_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pfclps_sva
  import pfclps_pkg::*;
#(
  parameter int unsigned SOA_OFF_CYCLES = 25
) (
  // clock, reset and watched inputs
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic driver_supply_ok_in,
  input wire logic feedback_overvoltage_in,
  input wire logic line_above_high_in,
  input wire logic switch_current_limit_in,
  // watched outputs
  input wire logic switch_enable_out,
  input wire logic end_on_time_out,
  input wire pfclps_pkg::pfclps_pwr_e power_level_out,
  input wire logic high_line_out,
  input wire logic [pfclps_pkg::ERR_W-1:0] error_voltage_limit_out,
  input wire logic safe_area_active_out,
  input wire logic overvoltage_out
);
  import pfclps_pkg::*;
  logic [7:0] soa_cnt_d;
  logic [7:0] soa_cnt_q;
  // length of the current forced off-time
  always_comb
  begin
    soa_cnt_d = safe_area_active_out ? soa_cnt_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_in)
  begin
    soa_cnt_q <= rst_in ? 8'h00 : soa_cnt_d;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  eot_follow_a: assert property (end_on_time_out == switch_current_limit_in)
    else $error("on-time end does not follow the current limit");
  reset_clear_a: assert property (disable iff (1'b0) rst_in |=> (error_voltage_limit_out == 0 &&
    !safe_area_active_out && !overvoltage_out && !high_line_out && power_level_out == PFCLPS_PWR_100))
    else $error("outputs not cleared by reset");
  ov_trip_a: assert property (feedback_overvoltage_in [*5] |-> overvoltage_out)
    else $error("overvoltage not flagged");
  ov_gate_a: assert property (overvoltage_out |-> !switch_enable_out)
    else $error("switching during overvoltage");
  soa_gate_a: assert property (safe_area_active_out |-> !switch_enable_out)
    else $error("switching during forced off-time");
  soa_len_a: assert property ($fell(safe_area_active_out) && !$past(rst_in) |->
    (int'(soa_cnt_q) + 1 >= SOA_OFF_CYCLES && int'(soa_cnt_q) <= SOA_OFF_CYCLES + 1))
    else $error("forced off-time has the wrong length");
  soa_end_a: assert property ($rose(safe_area_active_out) |-> ##[1:60] !safe_area_active_out)
    else $error("forced off-time does not end");
  soa_halve_a: assert property ($rose(safe_area_active_out) |-> ##[0:3] (error_voltage_limit_out < ERR_HALF))
    else $error("error ceiling not pulled down by half");
  high_line_a: assert property (line_above_high_in [*5] |-> high_line_out)
    else $error("high line not set from the instant level");
  pwr_hold_a: assert property (switch_enable_out && $past(switch_enable_out) |-> $stable(power_level_out))
    else $error("power level changed while switching");
  uvlo_gate_a: assert property (!driver_supply_ok_in [*5] |-> !switch_enable_out)
    else $error("switching without driver supply");
  cover property ($rose(safe_area_active_out));
  cover property ($rose(overvoltage_out));
  cover property ($fell(high_line_out));
  cover property ($fell(error_voltage_limit_out == 0));
endmodule
bind pfclps_supervisor pfclps_sva #(.SOA_OFF_CYCLES(SOA_OFF_CYCLES)) sva_i (.clk_in(clk_in),
  .rst_in(rst_in), .driver_supply_ok_in(driver_supply_ok_in),
  .feedback_overvoltage_in(feedback_overvoltage_in), .line_above_high_in(line_above_high_in),
  .switch_current_limit_in(switch_current_limit_in), .switch_enable_out(switch_enable_out),
  .end_on_time_out(end_on_time_out), .power_level_out(power_level_out),
  .high_line_out(high_line_out), .error_voltage_limit_out(error_voltage_limit_out),
  .safe_area_active_out(safe_area_active_out), .overvoltage_out(overvoltage_out));
`default_nettype wire

// File: verification/pfclps_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// line sense comparator bank, thresholds in bench units
module pfclps_line_model (
  // line level and peak strobe
  input wire logic [7:0] level_in,
  input wire logic peak_req_in,
  // comparator results
  output logic above_brown_in_out,
  output logic above_uv_out,
  output logic above_lowered_out,
  output logic above_sq_out,
  output logic peak_over_limit_out,
  output logic above_high_out,
  output logic peak_below_low_out,
  output logic peak_above_high_out,
  output logic half_cycle_peak_out
);
  assign above_brown_in_out = level_in > 8'h32;
  assign above_uv_out = level_in > 8'h28;
  assign above_lowered_out = level_in > 8'h1e;
  assign above_sq_out = level_in > 8'h14;
  assign peak_over_limit_out = level_in > 8'hc8;
  assign above_high_out = level_in > 8'h55;
  assign peak_below_low_out = level_in < 8'h46;
  assign peak_above_high_out = level_in > 8'h55;
  assign half_cycle_peak_out = peak_req_in;
endmodule
`default_nettype wire

// File: verification/pfc_line_protection_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_line_protection_supervisor_test;
  import pfclps_pkg::*;
  typedef struct packed {logic [1:0] ps; pfclps_pwr_e pwr;} pfclps_row_s;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ok = 1'b0, drv_ok = 1'b0, fb_ov = 1'b0, fb_hyst = 1'b0;
  logic zc = 1'b0, sw_on = 1'b0, ilim = 1'b0, peak_req = 1'b0;
  logic ot = 1'b0, sqw = 1'b0;
  logic [7:0] level = 8'h00;
  logic [1:0] ps = 2'h0;
  logic en, eot, hl, safe, ov, bi, uv, low, sq, lim, hi, pbl, pah, hcp;
  logic [9:0] err;
  pfclps_pwr_e pwr;
  int num_errors = 0;
  int checks = 0;
  int i;
  int j;
  pfclps_row_s rows [4] = '{'{2'h0, PFCLPS_PWR_100}, '{2'h1, PFCLPS_PWR_90},
    '{2'h2, PFCLPS_PWR_80}, '{2'h3, PFCLPS_PWR_70}};
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end
  pfclps_line_model cmp (.level_in(level), .peak_req_in(peak_req), .above_brown_in_out(bi),
    .above_uv_out(uv), .above_lowered_out(low), .above_sq_out(sq), .peak_over_limit_out(lim),
    .above_high_out(hi), .peak_below_low_out(pbl), .peak_above_high_out(pah),
    .half_cycle_peak_out(hcp));
  pfclps_supervisor #(.BROWNOUT_CYCLES(20), .EXT_BROWNOUT_CYCLES(30), .STARTUP_CYCLES(40),
    .DROPOUT_CYCLES(50), .SOFTOFF_CYCLES(20)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .bias_above_upper_in(ok), .bias_above_lower_in(ok), .driver_supply_ok_in(drv_ok),
    .pin_checks_ok_in(ok), .feedback_valid_in(ok), .over_temp_in(ot),
    .line_above_brown_in_in(bi), .line_above_undervoltage_in(uv), .line_above_lowered_in(low),
    .line_above_squarewave_in(sq), .line_peak_over_limit_in(lim), .line_square_wave_in(sqw),
    .line_zero_cross_in(zc), .line_above_high_in(hi), .half_cycle_peak_in(hcp),
    .peak_below_low_in(pbl), .peak_above_high_in(pah), .power_select_input_in(ps),
    .switch_on_in(sw_on), .switch_current_limit_in(ilim), .feedback_overvoltage_in(fb_ov),
    .feedback_below_hyst_in(fb_hyst), .switch_enable_out(en), .end_on_time_out(eot),
    .power_level_out(pwr), .high_line_out(hl), .error_voltage_limit_out(err),
    .safe_area_active_out(safe), .overvoltage_out(ov));
  task summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task smp(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // 0 enable, 1 ceiling, 2 safe area, 3 overvoltage, 4 high line
  function automatic logic [9:0] pick(input int k);
    case (k)
      0: return 10'(en);
      1: return err;
      2: return 10'(safe);
      3: return 10'(ov);
      default: return 10'(hl);
    endcase
  endfunction
  task wait_sig(input string name, input int k, input logic [9:0] v, input int n);
    @(negedge clk_in);
    for (i = 0; i < n && pick(k) !== v; i++)
      @(negedge clk_in);
    chk(name, v, pick(k));
    if (pick(k) !== v)
      summarize();
  endtask
  task start(input logic [1:0] code);
    @(posedge clk_in);
    rst_in <= 1'b1;
    ok <= 1'b1;
    drv_ok <= 1'b1;
    level <= 8'h64;
    ps <= code;
    cyc(2);
    rst_in <= 1'b0;
    wait_sig("switch_enable", 0, 10'h001, 200);
  endtask
  initial
  begin
    cyc(2);
    rst_in <= 1'b0;
    smp(2);
    chk("reset flags", 10'h000, {en, ov, safe, hl, pwr, 4'h0});
    chk("reset ceiling", 10'h000, err);
    $display("reset test done");
    foreach (rows[k])
    begin
      start(rows[k].ps);
      chk("power_level", 10'(rows[k].pwr), 10'(pwr));
      $display("row %0d done", k);
    end
    @(posedge clk_in) rst_in <= 1'b1;
    level <= 8'hd2;
    cyc(2);
    rst_in <= 1'b0;
    smp(40);
    chk("enable above peak limit", 10'h000, 10'(en));
    @(posedge clk_in) rst_in <= 1'b1;
    level <= 8'h64;
    ok <= 1'b0;
    ot <= 1'b1;
    cyc(2);
    rst_in <= 1'b0;
    smp(40);
    chk("enable before checks", 10'h000, 10'(en));
    @(posedge clk_in) ok <= 1'b1;
    smp(40);
    chk("enable in over-temp", 10'h000, 10'(en));
    @(posedge clk_in) ot <= 1'b0;
    wait_sig("switch_enable", 0, 10'h001, 100);
    $display("start-up test done");
    @(posedge clk_in) sw_on <= 1'b1;
    ilim <= 1'b1;
    smp(1);
    chk("end_on_time", 10'h001, 10'(eot));
    @(posedge clk_in) sw_on <= 1'b0;
    ilim <= 1'b0;
    wait_sig("safe_area", 2, 10'h001, 6);
    smp(2);
    chk("halved ceiling", 10'h1ff, err);
    wait_sig("safe_area end", 2, 10'h000, 40);
    @(posedge clk_in) sw_on <= 1'b1;
    cyc(20);
    ilim <= 1'b1;
    smp(4);
    chk("no safe area after long on-time", 10'h000, 10'(safe));
    @(posedge clk_in) sw_on <= 1'b0;
    ilim <= 1'b0;
    $display("safe area test done");
    @(posedge clk_in) fb_ov <= 1'b1;
    wait_sig("overvoltage", 3, 10'h001, 6);
    chk("enable in overvoltage", 10'h000, 10'(en));
    @(posedge clk_in) fb_ov <= 1'b0;
    smp(10);
    chk("overvoltage held", 10'h001, 10'(ov));
    @(posedge clk_in) fb_hyst <= 1'b1;
    wait_sig("overvoltage clear", 3, 10'h000, 6);
    wait_sig("enable after overvoltage", 0, 10'h001, 10);
    @(posedge clk_in) fb_hyst <= 1'b0;
    $display("overvoltage test done");
    @(posedge clk_in) level <= 8'h5a;
    wait_sig("high_line", 4, 10'h001, 6);
    @(posedge clk_in) level <= 8'h3c;
    for (j = 0; j < 3; j++)
    begin
      @(posedge clk_in) peak_req <= 1'b1;
      cyc(3);
      peak_req <= 1'b0;
      smp(4);
      chk("high_line after low peaks", 10'(j < 2), 10'(hl));
    end
    $display("line level test done");
    @(posedge clk_in) sqw <= 1'b1;
    level <= 8'h1a;
    smp(80);
    chk("enable on square wave", 10'h001, 10'(en));
    @(posedge clk_in) level <= 8'h64;
    smp(4);
    sqw <= 1'b0;
    smp(10);
    $display("square wave test done");
    @(posedge clk_in) level <= 8'h00;
    smp(100);
    chk("ceiling before zero cross", 10'h3ff, err);
    @(posedge clk_in) zc <= 1'b1;
    cyc(3);
    zc <= 1'b0;
    wait_sig("ceiling ramped to zero", 1, 10'h000, 40);
    wait_sig("enable after brown-out", 0, 10'h000, 10);
    @(posedge clk_in) level <= 8'h64;
    wait_sig("enable on restart", 0, 10'h001, 200);
    @(posedge clk_in) drv_ok <= 1'b0;
    wait_sig("enable without driver supply", 0, 10'h000, 10);
    $display("brown-out test done");
    summarize();
  end
endmodule
`default_nettype wire
